// >>> core/aspo_pkg.sv
`default_nettype none

package aspo_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] CTRL_ADDR  = 8'h98;
   localparam logic [7:0] DATA_ADDR  = 8'h99;
   localparam logic [7:0] CTRL_RESET = 8'h40;

   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int unsigned MODE_BIT  = 7;
   localparam int unsigned SPARE_BIT = 6;
   localparam int unsigned MCE_BIT   = 5;
   localparam int unsigned REN_BIT   = 4;
   localparam int unsigned TB8_BIT   = 3;
   localparam int unsigned RB8_BIT   = 2;
   localparam int unsigned TI_BIT    = 1;
   localparam int unsigned RI_BIT    = 0;

   // ************************************************************
   // frame geometry
   // ************************************************************
   localparam logic [3:0] STOP_IDX_8BIT  = 4'h9;
   localparam logic [3:0] STOP_IDX_9BIT  = 4'hA;
   localparam logic [3:0] LAST_DATA_8BIT = 4'h7;
   localparam logic [3:0] LAST_DATA_9BIT = 4'h8;

   // ************************************************************
   // bit timer
   // ************************************************************
   localparam logic [7:0] TIMER_TOP = 8'hFF;

   // one timer tick: {overflow, next count}; reload after the top value
   function automatic logic [8:0] timer_step(input logic [7:0] count,
                                             input logic [7:0] reload);
      logic [8:0] res;
      res = 9'h000;
      if (count == TIMER_TOP) begin
         res = {1'b1, reload};
      end else begin
         res = {1'b0, count + 8'h01};
      end
      return res;
   endfunction

endpackage

`default_nettype wire

// >>> core/aspo_rx_if.sv
`timescale 1ns/1ps
`default_nettype none

interface aspo_rx_if;
   logic       rxEnable;     // receiver enabled
   logic       mode9;        // 9-bit frame selected
   logic [7:0] reloadByte;   // timer reload value
   logic       timerTick;    // timer input clock pulse
   logic       frameDone;    // one-cycle pulse after stop sample
   logic [7:0] dataByte;     // received data byte
   logic       ninthField;   // ninth bit (9-bit) or stop bit (8-bit)

   modport ctrl (output rxEnable, output mode9, output reloadByte, output timerTick,
                 input frameDone, input dataByte, input ninthField);
   modport rcv  (input rxEnable, input mode9, input reloadByte, input timerTick,
                 output frameDone, output dataByte, output ninthField);
endinterface

`default_nettype wire

// >>> core/aspo_rx.sv
`timescale 1ns/1ps
`default_nettype none

module aspo_rx (
   input  wire logic ref_clk,      // system clock
   input  wire logic rst_n,        // async reset, active low
   input  wire logic serialInPin,  // receive line from far end
   aspo_rx_if.rcv    link          // to control logic
);

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } aspo_rx_state_t;

   aspo_rx_state_t rxState_q;
   logic           rxMeta_q;
   logic           rxSync_q;
   logic [7:0]     rxCount_q;
   logic           rxHalf_q;
   logic [3:0]     rxBitCnt_q;
   logic [8:0]     rxShift_q;
   logic           rxMode9_q;
   logic           frameDone_q;
   logic [7:0]     dataByte_q;
   logic           ninthField_q;
   logic [8:0]     rxStep;
   logic           rxOvf;
   logic           rxSample;
   logic           startSeen;

   assign rxStep    = aspo_pkg::timer_step(rxCount_q, link.reloadByte);
   assign rxOvf     = link.timerTick & rxStep[8];
   // two overflows per bit; the half flag picks the middle of each bit
   assign rxSample  = rxOvf & ~rxHalf_q;
   assign startSeen = (rxState_q == RX_IDLE) & link.rxEnable & ~rxSync_q;

   assign link.frameDone  = frameDone_q;
   assign link.dataByte   = dataByte_q;
   assign link.ninthField = ninthField_q;

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxMeta_q <= 1'b1;
         rxSync_q <= 1'b1;
      end else begin
         rxMeta_q <= serialInPin;
         rxSync_q <= rxMeta_q;
      end
   end

   // ************************************************************
   // receive bit timer
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxCount_q <= 8'h00;
         rxHalf_q  <= 1'b0;
      end else if (startSeen) begin
         rxCount_q <= link.reloadByte;
         rxHalf_q  <= 1'b0;
      end else if (link.timerTick) begin
         rxCount_q <= rxStep[7:0];
         if (rxOvf) begin
            rxHalf_q <= ~rxHalf_q;
         end
      end
   end

   // ************************************************************
   // frame sequencer
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxState_q    <= RX_IDLE;
         rxBitCnt_q   <= 4'h0;
         rxShift_q    <= 9'h000;
         rxMode9_q    <= 1'b0;
         frameDone_q  <= 1'b0;
         dataByte_q   <= 8'h00;
         ninthField_q <= 1'b0;
      end else begin
         frameDone_q <= 1'b0;
         if (!link.rxEnable) begin
            rxState_q <= RX_IDLE;
         end else begin
            case (rxState_q)
               RX_IDLE: begin
                  if (startSeen) begin
                     rxState_q  <= RX_START;
                     rxMode9_q  <= link.mode9;
                     rxBitCnt_q <= 4'h0;
                  end
               end
               RX_START: begin
                  // a glitch shorter than half a bit is dropped here
                  if (rxOvf) begin
                     rxState_q <= rxSync_q ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rxSample) begin
                     rxShift_q  <= {rxSync_q, rxShift_q[8:1]};
                     rxBitCnt_q <= rxBitCnt_q + 4'h1;
                     if (rxBitCnt_q == (rxMode9_q ? aspo_pkg::LAST_DATA_9BIT
                                                  : aspo_pkg::LAST_DATA_8BIT)) begin
                        rxState_q <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rxSample) begin
                     frameDone_q <= 1'b1;
                     rxState_q   <= RX_IDLE;
                     if (rxMode9_q) begin
                        dataByte_q   <= rxShift_q[7:0];
                        ninthField_q <= rxShift_q[8];
                     end else begin
                        dataByte_q   <= rxShift_q[8:1];
                        ninthField_q <= rxSync_q;
                     end
                  end
               end
               default: rxState_q <= RX_IDLE;
            endcase
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   rx_reload_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      startSeen |=> (rxCount_q == $past(link.reloadByte)) && (rxState_q == RX_START))
      else $error("receive timer not reloaded on start");

   rx_enable_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !link.rxEnable |=> (rxState_q == RX_IDLE) && !frameDone_q)
      else $error("receiver active while disabled");

endmodule

`default_nettype wire

// >>> core/aspo_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - bit rate is timer clock over (256 minus reload byte), halved.
// - control bit 7 selects frame: 0 for 8-bit, 1 for 9-bit.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bits.
// - 8-bit mode stores data in buffer and stop bit in received ninth bit.
// - writing the data buffer starts a transmit frame at once.
// - transmit complete flag sets when the stop bit starts, both modes.
// - receiver takes frames only while receive enable bit is one.
// - 8-bit load needs receive flag clear and, with filter on, stop bit one.
// - rejected frame leaves buffer, ninth bit and receive flag untouched.
// - on overrun the first byte stays; later frames are dropped.
// - interrupt request raised, when enabled, while either flag is set.
// - 9-bit frame: start, eight data LSB first, transmit ninth bit, stop.
// - 9-bit mode stores received ninth bit and ignores the stop bit.
// - 9-bit with filter on accepts only ninth bit one; off ignores it.
// - data location reads the receive buffer, writes the transmitter.
// - flags are never cleared by hardware, only by software writes.
// - receive timer reloads on start detection, apart from transmit timer.
module aspo_serial_port (
   input  wire logic       ref_clk,         // system clock, 20 MHz
   input  wire logic       rst_n,           // async reset, active low
   input  wire logic [7:0] sfrAddr,         // register address
   input  wire logic       sfrWrEn,         // write strobe, one cycle
   input  wire logic [7:0] sfrWrData,       // write data
   input  wire logic       sfrRdEn,         // read strobe, one cycle
   output var  logic [7:0] sfrRdData,       // read data, one cycle after strobe
   input  wire logic       timerTick,       // timer input clock pulse
   input  wire logic [7:0] timerReloadByte, // timer reload value
   input  wire logic       irqEnable,       // serial interrupt enabled
   output var  logic       irqReq,          // interrupt request level
   input  wire logic       serialInPin,     // receive line
   output var  logic       serialOutPin     // transmit line
);

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01,
      TX_STOP  = 2'b11
   } aspo_tx_state_t;

   aspo_rx_if rxLink ();

   logic           frameWidthSelect_q;
   logic           spareBit_q;
   logic           multiprocFilterEnable_q;
   logic           receiveEnableBit_q;
   logic           transmitNinthBit_q;
   logic           receivedNinthBit_q;
   logic           transmitCompleteFlag_q;
   logic           receiveCompleteFlag_q;
   logic [7:0]     serialOneDataBuffer_q;
   aspo_tx_state_t txState_q;
   logic [10:0]    txShift_q;
   logic [3:0]     txBitIdx_q;
   logic [3:0]     txStopIdx_q;
   logic [7:0]     txCount_q;
   logic           txHalf_q;
   logic [8:0]     txStep;
   logic           txBitTick;
   logic           ctrlWrite;
   logic           dataWrite;
   logic           rxAccept;
   logic           txStopStart;
   logic [3:0]     txNextIdx;
   logic [7:0]     ctrlValue;

   assign ctrlWrite = sfrWrEn && (sfrAddr == aspo_pkg::CTRL_ADDR);
   assign dataWrite = sfrWrEn && (sfrAddr == aspo_pkg::DATA_ADDR);
   assign txStep    = aspo_pkg::timer_step(txCount_q, timerReloadByte);
   // two overflows make one bit time
   assign txBitTick = timerTick & txStep[8] & txHalf_q;
   assign txNextIdx = txBitIdx_q + 4'h1;
   assign txStopStart = (txState_q == TX_SHIFT) && txBitTick && (txNextIdx == txStopIdx_q);
   // the ninth field is the stop bit in 8-bit mode, so one test serves both
   assign rxAccept  = !receiveCompleteFlag_q
                      && (!multiprocFilterEnable_q || rxLink.ninthField);
   assign ctrlValue = {frameWidthSelect_q, spareBit_q, multiprocFilterEnable_q,
                       receiveEnableBit_q, transmitNinthBit_q, receivedNinthBit_q,
                       transmitCompleteFlag_q, receiveCompleteFlag_q};

   assign rxLink.rxEnable   = receiveEnableBit_q;
   assign rxLink.mode9      = frameWidthSelect_q;
   assign rxLink.reloadByte = timerReloadByte;
   assign rxLink.timerTick  = timerTick;

   aspo_rx u_rx (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .serialInPin (serialInPin),
      .link        (rxLink)
   );

   // ************************************************************
   // control register
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frameWidthSelect_q      <= aspo_pkg::CTRL_RESET[aspo_pkg::MODE_BIT];
         spareBit_q              <= aspo_pkg::CTRL_RESET[aspo_pkg::SPARE_BIT];
         multiprocFilterEnable_q <= aspo_pkg::CTRL_RESET[aspo_pkg::MCE_BIT];
         receiveEnableBit_q      <= aspo_pkg::CTRL_RESET[aspo_pkg::REN_BIT];
         transmitNinthBit_q      <= aspo_pkg::CTRL_RESET[aspo_pkg::TB8_BIT];
      end else if (ctrlWrite) begin
         frameWidthSelect_q      <= sfrWrData[aspo_pkg::MODE_BIT];
         spareBit_q              <= sfrWrData[aspo_pkg::SPARE_BIT];
         multiprocFilterEnable_q <= sfrWrData[aspo_pkg::MCE_BIT];
         receiveEnableBit_q      <= sfrWrData[aspo_pkg::REN_BIT];
         transmitNinthBit_q      <= sfrWrData[aspo_pkg::TB8_BIT];
      end
   end

   // ************************************************************
   // status flags and receive buffer
   // ************************************************************
   // a hardware set in the same cycle as a software write wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         transmitCompleteFlag_q <= aspo_pkg::CTRL_RESET[aspo_pkg::TI_BIT];
      end else if (txStopStart) begin
         transmitCompleteFlag_q <= 1'b1;
      end else if (ctrlWrite) begin
         transmitCompleteFlag_q <= sfrWrData[aspo_pkg::TI_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         receiveCompleteFlag_q <= aspo_pkg::CTRL_RESET[aspo_pkg::RI_BIT];
         receivedNinthBit_q    <= aspo_pkg::CTRL_RESET[aspo_pkg::RB8_BIT];
         serialOneDataBuffer_q <= 8'h00;
      end else if (rxLink.frameDone && rxAccept) begin
         receiveCompleteFlag_q <= 1'b1;
         receivedNinthBit_q    <= rxLink.ninthField;
         serialOneDataBuffer_q <= rxLink.dataByte;
      end else if (ctrlWrite) begin
         // rejected or overrun frames fall through here untouched
         receiveCompleteFlag_q <= sfrWrData[aspo_pkg::RI_BIT];
         receivedNinthBit_q    <= sfrWrData[aspo_pkg::RB8_BIT];
      end
   end

   // ************************************************************
   // register reads
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfrRdData <= 8'h00;
      end else if (sfrRdEn) begin
         case (sfrAddr)
            aspo_pkg::CTRL_ADDR: sfrRdData <= ctrlValue;
            aspo_pkg::DATA_ADDR: sfrRdData <= serialOneDataBuffer_q;
            default:             sfrRdData <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // interrupt request
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= irqEnable && (transmitCompleteFlag_q || receiveCompleteFlag_q);
      end
   end

   // ************************************************************
   // transmit bit timer
   // ************************************************************
   // restarted on a buffer write so the start bit is a full bit time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txCount_q <= 8'h00;
         txHalf_q  <= 1'b0;
      end else if (dataWrite) begin
         txCount_q <= timerReloadByte;
         txHalf_q  <= 1'b0;
      end else if (timerTick) begin
         txCount_q <= txStep[7:0];
         if (txStep[8]) begin
            txHalf_q <= ~txHalf_q;
         end
      end
   end

   // ************************************************************
   // transmitter
   // ************************************************************
   // a write during a frame aborts it and starts the new byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txState_q    <= TX_IDLE;
         txShift_q    <= 11'h7FF;
         txBitIdx_q   <= 4'h0;
         txStopIdx_q  <= aspo_pkg::STOP_IDX_8BIT;
         serialOutPin <= 1'b1;
      end else if (dataWrite) begin
         txState_q    <= TX_SHIFT;
         txBitIdx_q   <= 4'h0;
         serialOutPin <= 1'b0;
         if (frameWidthSelect_q) begin
            txShift_q   <= {1'b1, transmitNinthBit_q, sfrWrData, 1'b0};
            txStopIdx_q <= aspo_pkg::STOP_IDX_9BIT;
         end else begin
            txShift_q   <= {2'b11, sfrWrData, 1'b0};
            txStopIdx_q <= aspo_pkg::STOP_IDX_8BIT;
         end
      end else if (txBitTick) begin
         case (txState_q)
            TX_SHIFT: begin
               txBitIdx_q   <= txNextIdx;
               serialOutPin <= txShift_q[txNextIdx];
               if (txNextIdx == txStopIdx_q) begin
                  txState_q <= TX_STOP;
               end
            end
            TX_STOP: begin
               txState_q    <= TX_IDLE;
               serialOutPin <= 1'b1;
            end
            TX_IDLE: serialOutPin <= 1'b1;
            default: txState_q <= TX_IDLE;
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   tx_start_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      dataWrite |=> !serialOutPin && (txState_q == TX_SHIFT) && (txBitIdx_q == 4'h0))
      else $error("transmit did not start on buffer write");

   ti_at_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      txStopStart && !dataWrite |=> transmitCompleteFlag_q && serialOutPin
                                   && (txState_q == TX_STOP))
      else $error("transmit flag not set at stop bit start");

   frame_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      dataWrite |=> (txStopIdx_q == ($past(frameWidthSelect_q) ? aspo_pkg::STOP_IDX_9BIT
                                                               : aspo_pkg::STOP_IDX_8BIT))
         && (txShift_q[9] == ($past(frameWidthSelect_q) ? $past(transmitNinthBit_q) : 1'b1)))
      else $error("stop bit at wrong frame position");

   tx_ninth_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (txState_q == TX_SHIFT) && (txBitIdx_q == 4'h9)
      && (txStopIdx_q == aspo_pkg::STOP_IDX_9BIT) |-> (serialOutPin == txShift_q[9]))
      else $error("ninth bit not driven in 9-bit frame");

   tx_timer_reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      timerTick && (txCount_q == 8'hFF) && !dataWrite |=> txCount_q == $past(timerReloadByte))
      else $error("transmit timer did not reload on overflow");

   rx_accept_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rxLink.frameDone && rxAccept |=> receiveCompleteFlag_q
         && (serialOneDataBuffer_q == $past(rxLink.dataByte))
         && (receivedNinthBit_q == $past(rxLink.ninthField)))
      else $error("accepted frame not loaded");

   rx_reject_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rxLink.frameDone && !rxAccept && !ctrlWrite |=> $stable(serialOneDataBuffer_q)
         && $stable(receivedNinthBit_q) && $stable(receiveCompleteFlag_q))
      else $error("rejected frame changed receive state");

   rx_overrun_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      receiveCompleteFlag_q && !ctrlWrite |=> $stable(serialOneDataBuffer_q))
      else $error("receive buffer overwritten on overrun");

   mce_filter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rxLink.frameDone && multiprocFilterEnable_q && !rxLink.ninthField
      && !receiveCompleteFlag_q && !ctrlWrite |=> !receiveCompleteFlag_q)
      else $error("filtered frame raised receive flag");

   irq_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irqEnable && (transmitCompleteFlag_q || receiveCompleteFlag_q) |=> irqReq)
      else $error("interrupt request missing");

   flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (transmitCompleteFlag_q || receiveCompleteFlag_q) && !ctrlWrite
      |=> $past(transmitCompleteFlag_q) <= transmitCompleteFlag_q
          && $past(receiveCompleteFlag_q) <= receiveCompleteFlag_q)
      else $error("flag cleared without software write");

endmodule

`default_nettype wire

// >>> sim/aspo_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// remote serial partner
// ************************************************************
module aspo_far_end (
   input  wire logic       ref_clk, // system clock
   input  wire logic       nine,    // 9-bit frames
   input  wire logic [7:0] bitCyc,  // clocks per bit
   input  wire logic       lineIn,  // device transmit line
   output var  logic       lineOut, // device receive line
   output var  logic [8:0] rxWord,  // {ninth or stop, data}
   output var  logic       rxValid  // one cycle per frame
);
   logic [10:0] frame;

   initial begin
      lineOut = 1'b1;
      rxValid = 1'b0;
      rxWord  = 9'h000;
   end

   // in 8-bit frames w[8] is the stop bit, so a bad stop can be sent
   task automatic send(input logic [8:0] w);
      frame = {1'b1, w, 1'b0};
      @(posedge ref_clk) #1;
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         lineOut = frame[i];
         repeat (bitCyc) @(posedge ref_clk);
         #1;
      end
      lineOut = 1'b1;
   endtask

   // mid-bit sampling keeps clear of the registered pin edges
   always begin
      @(negedge lineIn);
      repeat (bitCyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (bitCyc) @(posedge ref_clk);
         rxWord[i] = lineIn;
      end
      rxValid = 1'b1;
      @(posedge ref_clk) #1;
      rxValid = 1'b0;
   end
endmodule

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic       ref_clk, rst_n, sfrWrEn, sfrRdEn, irqEnable, irqReq;
   logic       timerTick, serialInPin, serialOutPin, rxValid, nine;
   logic       rdLate, b, acc;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, timerReloadByte, bitCyc;
   logic [7:0] d, bufExp;
   logic [8:0] rxWord;
   logic [7:0] expRd[$];
   logic [8:0] expTx[$];
   int         n_mismatch = 0, cmp_count = 0, seed = 65151;

   assign bitCyc = (8'h00 - timerReloadByte) << 1;

   aspo_serial_port uut (.ref_clk, .rst_n, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn,
      .sfrRdData, .timerTick, .timerReloadByte, .irqEnable, .irqReq, .serialInPin,
      .serialOutPin);
   aspo_far_end far (.ref_clk, .nine, .bitCyc, .lineIn(serialOutPin),
      .lineOut(serialInPin), .rxWord, .rxValid);

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ************************************************************
   // checking
   // ************************************************************
   task chk(input string nm, input logic [8:0] e, input logic [8:0] s);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   always @(posedge ref_clk) rdLate <= sfrRdEn;
   always @(negedge ref_clk) begin
      if (rdLate === 1'b1) chk("sfrRdData", {1'b0, expRd.pop_front()}, {1'b0, sfrRdData});
      if (rxValid === 1'b1) chk("txFrame", expTx.pop_front(), rxWord);
   end

   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ************************************************************
   // register bus
   // ************************************************************
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk) #1;
      sfrAddr = a;
      sfrWrData = v;
      sfrWrEn = 1'b1;
      @(posedge ref_clk) #1;
      sfrWrEn = 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      expRd.push_back(e);
      @(posedge ref_clk) #1;
      sfrAddr = a;
      sfrRdEn = 1'b1;
      @(posedge ref_clk) #1;
      sfrRdEn = 1'b0;
   endtask

   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      {sfrAddr, sfrWrData, sfrWrEn, sfrRdEn, nine, bufExp} = '0;
      irqEnable = 1'b1;
      timerTick = 1'b1;
      timerReloadByte = 8'hFC;
      rst_n = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      rd(8'h98, aspo_pkg::CTRL_RESET);
      wr(8'h42, 8'hFF);
      rd(8'h42, 8'h00);
      rd(8'h98, aspo_pkg::CTRL_RESET);
      wr(8'h98, 8'hFF);
      rd(8'h98, 8'hFF);
      chk("irqReq", 9'h001, {8'h00, irqReq});
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         b = 1'($random(seed));
         nine = i[0];
         timerReloadByte = i[1] ? 8'hFA : 8'hFC;
         wr(8'h98, {i[0], 1'b1, 2'b00, b, 3'b000});
         expTx.push_back({i[0] ? b : 1'b1, d});
         wr(8'h99, d);
         repeat (11 * bitCyc) @(posedge ref_clk);
         rd(8'h98, {i[0], 1'b1, 2'b00, b, 3'b010});
      end
      timerReloadByte = 8'hFC;
      for (int i = 0; i < 9; i++) begin
         d = 8'($random(seed));
         irqEnable = 1'($random(seed));
         nine = i[2];
         acc = !i[3] && (!i[1] || i[0]);
         wr(8'h98, {i[2], 1'b1, i[1], !i[3], 4'h0});
         far.send({i[0], d});
         repeat (4) @(posedge ref_clk);
         if (acc) bufExp = d;
         rd(8'h99, bufExp);
         rd(8'h98, {i[2], 1'b1, i[1], !i[3], 1'b0, acc & i[0], 1'b0, acc});
         chk("irqReq", {8'h00, irqEnable & acc}, {8'h00, irqReq});
      end
      wr(8'h98, 8'h50);
      d = 8'($random(seed));
      far.send({1'b1, d});
      far.send({1'b1, ~d});
      repeat (4) @(posedge ref_clk);
      rd(8'h99, d);
      rd(8'h98, 8'h55);
      give_verdict;
   end

   // the whole run needs about 1500 cycles
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      give_verdict;
   end
endmodule

`default_nettype wire
